// [pkg/timer8_cfg.svh]
// Purpose: register map, field positions and reset values of the 8-bit timer
// Assumes: APB byte addressing, one register per aligned 32-bit word
// Notes: all offsets are byte addresses
// Functional notes
// RQ1: clock select zero gives no count tick; the counter stays stopped.
// RQ2: codes 1 to 5 count on clock undivided, /8, /64, /256, /1024.
// RQ3: code 6 counts falling pin edges, code 7 rising pin edges.
// RQ4: pin edges count even when the pin is driven as an output.
// RQ5: software reads and writes the 8-bit counter at any time.
// RQ6: a counter write suppresses compare match on the next timer tick.
// RQ7: compare A is matched continuously; match flags and drives wave A.
// RQ8: compare B is matched continuously; match flags and drives wave B.
// RQ9: enable bits 2,1,0 for B, A, wrap; request needs enable, flag, global.
// RQ10: bits 7 to 3 of mask and flag registers read as zero.
// RQ11: compare B match sets flag bit 2.
// RQ12: compare A match sets flag bit 1.
// RQ13: counter overflow sets flag bit 0.
// RQ14: vector entry acknowledge clears the matching flag.
// RQ15: writing one to a flag bit clears that flag.
// RQ16: overflow flag timing depends on the waveform mode.
// RQ17: wrap at 0xFF in modes 0,2,3; at 0x00 in 1,5; at top in 7.
// RQ18: writing zero keeps a flag; a hardware set beats a clear.
`ifndef TIMER8_CFG_SVH
`define TIMER8_CFG_SVH

`define OFS_CONTROL 12'h000
`define OFS_COUNT 12'h004
`define OFS_CMP_A 12'h008
`define OFS_CMP_B 12'h00C
`define OFS_MASK 12'h010
`define OFS_FLAG 12'h014
`define OFS_FLAG_CLR 12'h018
`define OFS_GLOBAL 12'h01C

// control register fields
`define CTL_CS_LSB 0
`define CTL_WGM_LSB 3
`define CTL_COMA_LSB 6
`define CTL_COMB_LSB 8

// flag and mask bit positions
`define BIT_WRAP 0
`define BIT_CMP_A 1
`define BIT_CMP_B 2

`define CNT_MAX 8'hFF
`define CNT_BOTTOM 8'h00
`define RESET_BYTE 8'h00
`define PRE_WIDTH 10

`endif

// [pkg/timer8_pkg.sv]
// Purpose: types shared by the 8-bit timer
// Assumes: nothing
// Notes: clock select and waveform codes
package timer8_pkg;
    typedef enum logic [2:0] {
        CS_STOP, CS_DIV1, CS_DIV8, CS_DIV64,
        CS_DIV256, CS_DIV1024, CS_EXT_FALL, CS_EXT_RISE
    } clock_sel_t;

    typedef struct packed {
        logic [1:0] com_b;
        logic [1:0] com_a;
        logic [2:0] waveform_mode;
        logic [2:0] count_clock_select;
    } ctl_t;

    typedef struct packed {
        logic cmp_b;
        logic cmp_a;
        logic wrap;
    } irq_bits_t;
endpackage

// [design/timer8_tick_gen.sv]
// Purpose: timer tick generator: prescaler and external pin edge detect
// Assumes: ext pin asynchronous, synchronised here by two flops
// Notes: output is a one-cycle tick pulse
`timescale 1ns/1ps
`include "timer8_cfg.svh"
module timer8_tick_gen
    import timer8_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] count_clock_select,
    input wire logic ext_count_pin,
    output logic tick
);
    logic [`PRE_WIDTH-1:0] pre_q;
    logic sync1_q, sync2_q, prev_q;
    logic tick_d;

    // shared free-running prescaler; taps give the divided rates
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + 1'b1;
        end
    end

    // pin passes two flops; the pin buffer reads back even when driven
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            sync1_q <= ext_count_pin;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;  // see RQ4
        end
    end

    // tap selection per clock select code
    always_comb begin
        unique case (clock_sel_t'(count_clock_select))
            CS_STOP: tick_d = 1'b0;  // see RQ1
            CS_DIV1: tick_d = 1'b1;  // see RQ2
            CS_DIV8: tick_d = &pre_q[2:0];
            CS_DIV64: tick_d = &pre_q[5:0];
            CS_DIV256: tick_d = &pre_q[7:0];
            CS_DIV1024: tick_d = &pre_q[9:0];
            CS_EXT_FALL: tick_d = prev_q & ~sync2_q;  // see RQ3
            CS_EXT_RISE: tick_d = ~prev_q & sync2_q;  // see RQ3
        endcase
    end

    assign tick = tick_d;

    a_stop_no_tick: assert property (  // see RQ1
        @(posedge pclk) disable iff (!presetn)
        count_clock_select == 3'h0 |-> !tick)
        else $error("tick while stopped");
    a_div8_spacing: assert property (  // see RQ2
        @(posedge pclk) disable iff (!presetn)
        (tick && count_clock_select == 3'h2 && $stable(count_clock_select))
        |=> !tick [*7])
        else $error("divide by 8 tick too early");
endmodule

// [design/timer8.sv]
// Purpose: 8-bit timer with clock select, two compares, flags, APB slave
// Assumes: APB3 slave, zero wait states, 32-bit data, pclk 25 MHz
// Notes: flags and irq are registered; a hardware set beats a clear
`timescale 1ns/1ps
`include "timer8_cfg.svh"
module timer8
    import timer8_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_count_pin,
    input wire logic [2:0] vector_ack,
    output logic wave_out_a,
    output logic wave_out_b,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////
    // state
    ctl_t ctl_q;
    logic [7:0] count_value_q;
    logic [7:0] compare_a_value_q, compare_b_value_q;
    logic [7:0] top_a_q;
    irq_bits_t mask_q, flag_q;
    logic global_ie_q;
    logic up_q;
    logic block_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic irq_q;
    logic wa_q, wb_q;
    logic tick;
    logic wr, rd, hit;
    logic cnt_wr;
    logic [7:0] top;
    logic m_a, m_b, wrap_ev;
    irq_bits_t set_v, clr_v;
    irq_bits_t flag_d;
    logic [2:0] wgm;

    // decode helper that raises the slave error on unmapped addresses
    function automatic logic is_reg(input logic [11:0] a);
        return a == `OFS_CONTROL || a == `OFS_COUNT || a == `OFS_CMP_A ||
               a == `OFS_CMP_B || a == `OFS_MASK || a == `OFS_FLAG ||
               a == `OFS_FLAG_CLR || a == `OFS_GLOBAL;
    endfunction

    // pwm modes use double buffered compare A, other modes are immediate
    function automatic logic pwm_mode(input logic [2:0] m);
        return m == 3'h1 || m == 3'h3 || m == 3'h5 || m == 3'h7;
    endfunction

    // phase correct modes count both ways and wrap at bottom
    function automatic logic phase_mode(input logic [2:0] m);
        return m == 3'h1 || m == 3'h5;
    endfunction

    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;
    assign hit = is_reg(paddr);
    assign cnt_wr = wr && paddr == `OFS_COUNT;
    assign wgm = ctl_q.waveform_mode;

    ////////////////////////////////////////////////////////////////////////
    // timer tick
    timer8_tick_gen u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .count_clock_select(ctl_q.count_clock_select),
        .ext_count_pin(ext_count_pin),
        .tick(tick)
    );

    // top follows compare A in modes 2, 5 and 7, else the full range
    assign top = (wgm == 3'h2 || wgm == 3'h5 || wgm == 3'h7) ?
                 top_a_q : `CNT_MAX;

    // matches only count on a tick, and not right after a counter write
    assign m_a = tick && !block_q && count_value_q == top_a_q;  // see RQ7
    assign m_b = tick && !block_q &&
                 count_value_q == compare_b_value_q;  // see RQ8

    // overflow point per waveform mode
    always_comb begin
        unique case (wgm)
            3'h1, 3'h5: wrap_ev = tick && !up_q &&
                                  count_value_q == 8'h01;  // see RQ17
            3'h7: wrap_ev = tick && count_value_q == top;  // see RQ17
            default: wrap_ev = tick &&
                               count_value_q == `CNT_MAX;  // see RQ16
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // APB control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= '0;
            compare_a_value_q <= `RESET_BYTE;
            compare_b_value_q <= `RESET_BYTE;
            mask_q <= '0;
            global_ie_q <= 1'b0;
        end else if (wr) begin
            unique case (paddr)
                `OFS_CONTROL: ctl_q <= pwdata[9:0];
                `OFS_CMP_A: compare_a_value_q <= pwdata[7:0];
                `OFS_CMP_B: compare_b_value_q <= pwdata[7:0];
                `OFS_MASK: mask_q <= pwdata[2:0];  // see RQ9
                `OFS_GLOBAL: global_ie_q <= pwdata[0];
                default: ;
            endcase
        end
    end

    // working compare A: loaded at once, or at bottom in pwm modes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            top_a_q <= `RESET_BYTE;
        end else if (!pwm_mode(wgm) ||
                     (tick && count_value_q == `CNT_BOTTOM)) begin
            top_a_q <= compare_a_value_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // counter: a software write wins over counting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_value_q <= `RESET_BYTE;
            up_q <= 1'b1;
        end else if (cnt_wr) begin
            count_value_q <= pwdata[7:0];  // see RQ5
        end else if (tick) begin
            if (phase_mode(wgm)) begin
                // phase correct: turn at top and at bottom
                if (up_q && count_value_q == top) begin
                    up_q <= 1'b0;
                    count_value_q <= count_value_q - 8'h01;
                end else if (!up_q && count_value_q == `CNT_BOTTOM) begin
                    up_q <= 1'b1;
                    count_value_q <= count_value_q + 8'h01;
                end else begin
                    count_value_q <= up_q ? count_value_q + 8'h01 :
                                            count_value_q - 8'h01;
                end
            end else if (count_value_q == top) begin
                up_q <= 1'b1;
                count_value_q <= `CNT_BOTTOM;
            end else begin
                up_q <= 1'b1;
                count_value_q <= count_value_q + 8'h01;
            end
        end
    end

    // compare blocking after a write lasts until the next tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_q <= 1'b0;
        end else if (cnt_wr) begin
            block_q <= 1'b1;  // see RQ6
        end else if (tick) begin
            block_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flags: set wins over clear by write-one or vector acknowledge
    assign set_v = '{cmp_b: m_b, cmp_a: m_a, wrap: wrap_ev};
    assign clr_v = vector_ack |  // see RQ14
                   ((wr && paddr == `OFS_FLAG_CLR) ? pwdata[2:0] :
                    3'h0);  // see RQ15
    // next flag word, shared by the flag register and the irq term
    assign flag_d = set_v | (flag_q & ~clr_v);  // see RQ18

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= '0;
        end else begin
            flag_q <= flag_d;  // see RQ18
            // sets come from compare and wrap events
            // see RQ11
            // see RQ12
            // see RQ13
        end
    end

    // interrupt output needs global enable, mask and flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            // mask the whole next word, fresh sets too, so an event
            // on a disabled source never pulses the line
            irq_q <= global_ie_q && |(flag_d & mask_q);  // see RQ9
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // waveform outputs: toggle, clear or set on match (non-pwm view)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wa_q <= 1'b0;
            wb_q <= 1'b0;
        end else begin
            if (m_a) begin
                unique case (ctl_q.com_a)
                    2'h1: wa_q <= ~wa_q;
                    2'h2: wa_q <= 1'b0;
                    2'h3: wa_q <= 1'b1;
                    default: ;
                endcase
            end else if (pwm_mode(wgm) && ctl_q.com_a[1] && tick &&
                         count_value_q == top && !up_q == 1'b0) begin
                wa_q <= ~ctl_q.com_a[0];
            end
            if (m_b) begin
                unique case (ctl_q.com_b)
                    2'h1: wb_q <= ~wb_q;
                    2'h2: wb_q <= 1'b0;
                    2'h3: wb_q <= 1'b1;
                    default: ;
                endcase
            end else if (pwm_mode(wgm) && ctl_q.com_b[1] && tick &&
                         count_value_q == top) begin
                wb_q <= ~ctl_q.com_b[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, registered; reserved bits read zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
            if (psel && !penable) begin
                pslverr_q <= !hit;
                unique case (paddr)
                    `OFS_CONTROL: prdata_q <= {22'h0, ctl_q};
                    `OFS_COUNT: prdata_q <= {24'h0, count_value_q};
                    `OFS_CMP_A: prdata_q <= {24'h0, compare_a_value_q};
                    `OFS_CMP_B: prdata_q <= {24'h0, compare_b_value_q};
                    `OFS_MASK: prdata_q <= {29'h0, mask_q};  // see RQ10
                    `OFS_FLAG: prdata_q <= {29'h0, flag_q};  // see RQ10
                    `OFS_GLOBAL: prdata_q <= {31'h0, global_ie_q};
                    default: ;
                endcase
            end
        end
    end

    assign prdata = prdata_q;
    assign pslverr = pslverr_q;
    assign pready = 1'b1;
    assign irq = irq_q;
    assign wave_out_a = wa_q;
    assign wave_out_b = wb_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    // counting
    a_stop_holds: assert property (  // see RQ1
        @(posedge pclk) disable iff (!presetn)
        (ctl_q.count_clock_select == 3'h0 && !cnt_wr)
        |=> $stable(count_value_q))
        else $error("counter moved while stopped");
    a_count_tick: assert property (  // see RQ2
        @(posedge pclk) disable iff (!presetn)
        (ctl_q.count_clock_select == 3'h1 && wgm == 3'h0 && !cnt_wr)
        |=> count_value_q == $past(count_value_q) + 8'h01)
        else $error("undivided clock missed a count");
    a_count_write: assert property (  // see RQ5
        @(posedge pclk) disable iff (!presetn)
        cnt_wr |=> count_value_q == $past(pwdata[7:0]))
        else $error("counter write lost");
    // judged on the flags, so a broken block term shows up there
    a_write_blocks: assert property (  // see RQ6
        @(posedge pclk) disable iff (!presetn)
        (block_q && tick)
        |=> !$rose(flag_q.cmp_a) && !$rose(flag_q.cmp_b))
        else $error("match right after counter write");
    a_phase_wrap: assert property (  // see RQ17
        @(posedge pclk) disable iff (!presetn)
        (phase_mode(wgm) && $stable(wgm) && !$past(cnt_wr) &&
         $rose(flag_q.wrap))
        |-> count_value_q == `CNT_BOTTOM)
        else $error("phase correct wrap away from bottom");

    // flags and interrupt
    a_cmp_b_sets: assert property (  // see RQ11
        @(posedge pclk) disable iff (!presetn)
        m_b |=> flag_q.cmp_b)
        else $error("compare B flag not set");
    a_cmp_a_sets: assert property (  // see RQ12
        @(posedge pclk) disable iff (!presetn)
        m_a |=> flag_q.cmp_a)
        else $error("compare A flag not set");
    a_wrap_sets: assert property (  // see RQ17
        @(posedge pclk) disable iff (!presetn)
        (wgm == 3'h0 && tick && !cnt_wr && count_value_q == 8'hFF)
        |=> flag_q.wrap && count_value_q == 8'h00)
        else $error("wrap flag missing");
    a_clear_one: assert property (  // see RQ15
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == `OFS_FLAG_CLR && pwdata[0] && !wrap_ev)
        |=> !flag_q.wrap)
        else $error("flag not cleared");
    a_zero_keeps: assert property (  // see RQ18
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == `OFS_FLAG_CLR && !pwdata[2] && !vector_ack[2] &&
         flag_q.cmp_b)
        |=> flag_q.cmp_b)
        else $error("writing zero cleared a flag");
    a_ack_clears: assert property (  // see RQ14
        @(posedge pclk) disable iff (!presetn)
        (vector_ack[1] && !m_a) |=> !flag_q.cmp_a)
        else $error("ack did not clear");
    a_irq_gate: assert property (  // see RQ9
        @(posedge pclk) disable iff (!presetn)
        irq |-> $past(global_ie_q))
        else $error("irq without global enable");
    a_irq_masked: assert property (  // see RQ9
        @(posedge pclk) disable iff (!presetn)
        irq |-> |(flag_q & $past(mask_q)))
        else $error("irq without an enabled flag");

    // register reads
    a_reserved_zero: assert property (  // see RQ10
        @(posedge pclk) disable iff (!presetn)
        prdata[31:10] == 22'h0)
        else $error("reserved bits set");
    a_mask_read: assert property (  // see RQ10
        @(posedge pclk) disable iff (!presetn)
        (rd && paddr == `OFS_MASK) |-> prdata[7:0] == {5'h0, mask_q})
        else $error("mask read wrong");
    a_flag_read: assert property (  // see RQ10
        @(posedge pclk) disable iff (!presetn)
        (rd && paddr == `OFS_FLAG) |-> prdata[7:0] == {5'h0, $past(flag_q)})
        else $error("flag read wrong");

    c_wrap: cover property (@(posedge pclk) wrap_ev);
    c_match_a: cover property (@(posedge pclk) m_a ##1 irq);
    c_ext: cover property (@(posedge pclk)
        ctl_q.count_clock_select == 3'h7 && tick);
    c_block: cover property (@(posedge pclk) block_q && tick);
    c_phase_wrap: cover property (@(posedge pclk)
        phase_mode(wgm) && wrap_ev);
endmodule

// [verification/ext_count_src.sv]
// Purpose: far-side model driving the external count pin
// Assumes: the pin is a held push-pull level, never released
// Notes: edge spacing in clock cycles gives a prompt or a slow source
`timescale 1ns/1ps
module ext_count_src (
    input wire logic pclk,
    output logic ext_count_pin
);
    // idle low from time zero so the synchroniser starts defined
    initial begin
        ext_count_pin = 1'b0;
    end

    // n edges, gap cycles apart; the level is held after the last one
    // since the same pin may be an output of the device, which still
    // counts its own edges
    task automatic toggle(input int n, input int gap);
        repeat (n) begin
            repeat (gap) @(posedge pclk);
            ext_count_pin <= ~ext_count_pin;
        end
    endtask
endmodule

// [verification/tb_top.sv]
// Purpose: self-checking bench for the 8-bit timer slice
// Assumes: zero-wait APB slave, flags and irq registered
// Notes: the prescaler runs free, so divided counts get one tick slack
`timescale 1ns/1ps
`include "timer8_cfg.svh"
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic ext_count_pin, wave_out_a, wave_out_b, irq;
    logic [2:0] vector_ack;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;

    timer8 i_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .ext_count_pin, .vector_ack,
        .wave_out_a, .wave_out_b, .irq
    );
    ext_count_src i_src (.pclk, .ext_count_pin);

    ////////////////////////////////////////
    // 25 MHz bus clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // hang guard, far above the few thousand cycles the run needs
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fail_count++;
            results();
        end
    end

    task automatic check(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one transfer; the request stands until pready is seen high,
    // read data and error are taken at that same edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input string nm, input logic [11:0] a,
                         input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(nm, rd, exp);
    endtask

    task automatic run(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // run with control word c for n cycles, then stop the counter
    task automatic go(input logic [31:0] c, input int n);
        wr(`OFS_CONTROL, c);
        run(n);
        wr(`OFS_CONTROL, 32'h0);
    endtask

    ////////////////////////////////////////
    // reset values, reserved mask bits, refused place, stopped count
    task automatic t_reset;
        rdchk("control", `OFS_CONTROL, 32'h0);
        rdchk("flags", `OFS_FLAG, 32'h0);
        check("irq", 32'(irq), 32'h0);
        wr(`OFS_MASK, 32'hFF);
        rdchk("mask", `OFS_MASK, 32'h7);
        wr(12'h040, 32'hFF);
        check("slverr", 32'(err), 32'h1);
        rdchk("unmapped", 12'h040, 32'h0);
        wr(`OFS_CMP_B, 32'hA5);
        rdchk("cmp_b", `OFS_CMP_B, 32'hA5);
        wr(`OFS_COUNT, 32'h5A);
        run(20);
        rdchk("stopped", `OFS_COUNT, 32'h5A);
    endtask

    // codes 1 to 5 divide the clock by 1, 8, 64, 256, 1024
    task automatic t_prescale;
        int dv[5] = '{1, 8, 64, 256, 1024};
        int el, t0;
        for (int i = 0; i < 5; i++) begin
            wr(`OFS_COUNT, 32'h0);
            wr(`OFS_CONTROL, 32'(i + 1));
            t0 = cyc;
            run(3 * dv[i]);
            wr(`OFS_CONTROL, 32'h0);
            el = (cyc - t0) / dv[i];
            apb(1'b0, `OFS_COUNT, 32'h0);
            check("div", 32'(rd + 1 >= el && rd <= el + 1), 32'h1);
        end
    endtask

    // pin edges: slow source on rising, prompt source on falling
    task automatic t_ext;
        wr(`OFS_COUNT, 32'h0);
        wr(`OFS_CONTROL, 32'h7);
        i_src.toggle(5, 6);
        go(32'h7, 6);
        rdchk("ext_rise", `OFS_COUNT, 32'h3);
        wr(`OFS_COUNT, 32'h0);
        wr(`OFS_CONTROL, 32'h6);
        i_src.toggle(5, 2);
        go(32'h6, 6);
        rdchk("ext_fall", `OFS_COUNT, 32'h3);
    endtask

    // both matches toggle their outputs and set flags; irq gating
    task automatic t_compare;
        wr(`OFS_CMP_A, 32'h10);
        wr(`OFS_CMP_B, 32'h20);
        wr(`OFS_COUNT, 32'h08);
        wr(`OFS_CONTROL, 32'h141);
        run(40);
        check("wave_a", 32'(wave_out_a), 32'h1);
        check("wave_b", 32'(wave_out_b), 32'h1);
        wr(`OFS_CONTROL, 32'h0);
        rdchk("flags_ab", `OFS_FLAG, 32'h6);
        wr(`OFS_MASK, 32'h2);
        wr(`OFS_GLOBAL, 32'h1);
        run(2);
        check("irq_a", 32'(irq), 32'h1);
        wr(`OFS_GLOBAL, 32'h0);
        run(2);
        check("irq_gie", 32'(irq), 32'h0);
        wr(`OFS_FLAG_CLR, 32'h2);
        rdchk("clr_a", `OFS_FLAG, 32'h4);
    endtask

    // wrap past 0xFF in normal mode, then vector entries clear flags
    task automatic t_wrap;
        wr(`OFS_MASK, 32'h1);
        wr(`OFS_GLOBAL, 32'h1);
        wr(`OFS_COUNT, 32'hFC);
        go(32'h1, 8);
        rdchk("wrap", `OFS_FLAG, 32'h5);
        check("irq_wrap", 32'(irq), 32'h1);
        wr(`OFS_COUNT, 32'h0E);
        go(32'h1, 25);
        rdchk("all", `OFS_FLAG, 32'h7);
        for (int i = 0; i < 3; i++) begin
            vector_ack <= 3'(1 << i);
            @(posedge pclk);
            vector_ack <= 3'h0;
            rdchk("ack", `OFS_FLAG, (32'h6 << i) & 32'h7);
        end
        check("irq_ack", 32'(irq), 32'h0);
    endtask

    // a counter write blocks the match on the first tick after it
    task automatic t_block;
        wr(`OFS_CMP_A, 32'h30);
        wr(`OFS_COUNT, 32'h30);
        go(32'h1, 4);
        rdchk("blocked", `OFS_FLAG, 32'h0);
        wr(`OFS_COUNT, 32'h2F);
        go(32'h1, 4);
        rdchk("unblocked", `OFS_FLAG, 32'h2);
    endtask

    // phase correct: no wrap flag at 0xFF, set back at 0x00
    task automatic t_phase;
        wr(`OFS_FLAG_CLR, 32'h7);
        wr(`OFS_COUNT, 32'hF8);
        wr(`OFS_CONTROL, 32'h9);
        run(12);
        rdchk("pc_top", `OFS_FLAG, 32'h0);
        go(32'h9, 262);
        apb(1'b0, `OFS_FLAG, 32'h0);
        check("pc_bottom", rd & 32'h5, 32'h5);
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // reset held for 12 cycles, then the scenarios in turn
    initial begin
        {presetn, psel, penable, pwrite, vector_ack, paddr, pwdata} = 51'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_prescale();
        t_ext();
        t_compare();
        t_wrap();
        t_block();
        t_phase();
        results();
    end
endmodule
